// file: rtl/phy_status_pkg.sv
// Register indexes, field positions and reset values of the quick status bank
package phy_status_pkg;

	// Register indexes: byte address is four times the index
	localparam logic [4:0] IDX_BASIC_MODE_STATUS  = 5'h01;
	localparam logic [4:0] IDX_AUTONEG_EXPANSION  = 5'h06;
	localparam logic [4:0] IDX_PHY_QUICK_STATUS   = 5'h10;
	localparam logic [4:0] IDX_INTERRUPT_ENABLE   = 5'h11;
	localparam logic [4:0] IDX_INTERRUPT_SOURCE   = 5'h12;
	localparam logic [4:0] IDX_FALSE_CARRIER_CNT  = 5'h14;

	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int REG_W  = 16;
	localparam int INT_W  = 8;
	localparam int CNT_W  = 8;

	// Quick status field positions
	localparam int QS_FALSE_CARRIER  = 11;
	localparam int QS_SIGNAL_DETECT  = 10;
	localparam int QS_DESCRAM_LOCK   = 9;
	localparam int QS_PAGE_RECEIVED  = 8;
	localparam int QS_INT_PENDING    = 7;
	localparam int QS_REMOTE_FAULT   = 6;
	localparam int QS_JABBER         = 5;

	// Basic mode status and expansion field positions
	localparam int BMS_REMOTE_FAULT  = 4;
	localparam int BMS_LINK_STATUS   = 2;
	localparam int BMS_JABBER        = 1;
	localparam int ANX_PAGE_RECEIVED = 1;

	// Values after reset and the false carrier counter limit
	localparam logic             RST_FLAG       = 1'b0;
	localparam logic [INT_W-1:0] RST_INT_ENABLE = 8'h00;
	localparam logic [INT_W-1:0] RST_INT_SOURCE = 8'h00;
	localparam logic [CNT_W-1:0] RST_FC_COUNT   = 8'h00;
	localparam logic [CNT_W-1:0] FC_COUNT_MAX   = 8'hff;
	localparam logic [DATA_W-1:0] READ_ZERO     = 32'h0000_0000;

	// Synchroniser depth
	localparam int SYNC_STAGES = 2;

endpackage

// file: rtl/bit_sync.sv
// Two-flop synchroniser for a bundle of unrelated level inputs
module bit_sync
	import phy_status_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic [SYNC_STAGES-1:0] stage_q;
			always_ff @(posedge clock or posedge reset) begin
				if (reset) begin
					stage_q <= '0;
				end else begin
					stage_q <= {stage_q[SYNC_STAGES-2:0], async_in[i]};
				end
			end
			assign sync_out[i] = stage_q[SYNC_STAGES-1];
		end
	endgenerate

endmodule

// file: rtl/sticky_flag.sv
// Latch-high flags: set wins over a clear in the same cycle
module sticky_flag
	import phy_status_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] set,
	input  wire logic             clear,
	output logic      [WIDTH-1:0] flag
);

	logic [WIDTH-1:0] flag_q;
	logic [WIDTH-1:0] flag_d;

	assign flag_d = set | (flag_q & {WIDTH{~clear}});
	assign flag   = flag_q;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			flag_q <= {WIDTH{RST_FLAG}};
		end else begin
			flag_q <= flag_d;
		end
	end

endmodule

// file: rtl/phy_quick_status.sv
// Middle status bits of the quick status register behind an Avalon-MM slave
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Bit 11 set after false carrier since counter read
// - False carrier latch cleared by counter register read
// - Bit 10 latch-low signal detect, resets zero
// - Bit 9 latch-low descrambler lock, resets zero
// - Bit 8 reads one after new page
// - Page bit mirrors expansion bit 1, cleared there
// - Status read leaves page and jabber bits
// - Bit 7 shows any pending interrupt whose source is enabled
// - Interrupt source read clears pending indication
// - Bit 6 set on partner remote fault
// - Remote fault cleared by basic status read, reset
// - Bit 5 jabber, detected only at 10 Mb/s
// - Jabber bit copies basic status jabber bit
//
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
module phy_quick_status
	import phy_status_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              reset,
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [DATA_W-1:0] writedata,
	input  wire logic [3:0]        byteenable,
	output logic      [DATA_W-1:0] readdata,
	output logic                   waitrequest,
	input  wire logic              false_carrier_in,
	input  wire logic              signal_detect_in,
	input  wire logic              descrambler_lock_in,
	input  wire logic              page_received_in,
	input  wire logic              remote_fault_in,
	input  wire logic              jabber_in,
	input  wire logic              link_up_in,
	input  wire logic              speed_10_in,
	input  wire logic [INT_W-1:0]  int_event_in
);

	//////////////////////////////////////////////////////////////////////////
	// Address decode for the read side effects and the enable write; the read mux decodes on its own

	function automatic logic hit(input logic [ADDR_W-1:0] addr,
	                             input logic [ADDR_W-1:0] idx);
		hit = (addr == idx);
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	localparam int NUM_LEVELS = 8;

	logic [NUM_LEVELS-1:0] level_async;
	logic [NUM_LEVELS-1:0] level_sync;
	logic [INT_W-1:0]      int_event_sync;

	assign level_async = {false_carrier_in, signal_detect_in, descrambler_lock_in, page_received_in,
	                      remote_fault_in, jabber_in, link_up_in, speed_10_in};

	bit_sync #(
		.WIDTH (NUM_LEVELS)
	) u_level_sync (
		.clock    (clock),
		.reset    (reset),
		.async_in (level_async),
		.sync_out (level_sync)
	);

	bit_sync #(
		.WIDTH (INT_W)
	) u_int_sync (
		.clock    (clock),
		.reset    (reset),
		.async_in (int_event_in),
		.sync_out (int_event_sync)
	);

	wire false_carrier_s = level_sync[7];
	wire signal_detect_s = level_sync[6];
	wire descram_lock_s  = level_sync[5];
	wire page_rx_s       = level_sync[4];
	wire remote_fault_s  = level_sync[3];
	wire jabber_s        = level_sync[2];
	wire link_up_s       = level_sync[1];
	wire speed_10_s      = level_sync[0];

	//////////////////////////////////////////////////////////////////////////
	// Bus handshake: one wait state on every access

	logic ack_q;
	logic ack_d;

	wire access   = read | write;
	wire rd_take  = read & ~ack_q;
	wire wr_take  = write & ack_q;

	assign ack_d       = access & ~ack_q;
	assign waitrequest = access & ~ack_q;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= ack_d;
		end
	end

	// Read side effects fire on the edge that captures read data,
	// so an event landing on that edge is missed by that read but kept for the next.
	wire rd_basic_status = rd_take & hit(address, IDX_BASIC_MODE_STATUS);
	wire rd_expansion    = rd_take & hit(address, IDX_AUTONEG_EXPANSION);
	wire rd_quick_status = rd_take & hit(address, IDX_PHY_QUICK_STATUS);
	wire rd_int_source   = rd_take & hit(address, IDX_INTERRUPT_SOURCE);
	wire rd_fc_counter   = rd_take & hit(address, IDX_FALSE_CARRIER_CNT);
	wire wr_int_enable   = wr_take & hit(address, IDX_INTERRUPT_ENABLE) & byteenable[0];

	//////////////////////////////////////////////////////////////////////////
	// False carrier counter and latch

	logic             fc_prev_q;
	logic [CNT_W-1:0] fc_count_q;
	logic [CNT_W-1:0] fc_count_d;
	logic             fc_latch;

	wire fc_event = false_carrier_s & ~fc_prev_q;
	wire fc_sat   = (fc_count_q == FC_COUNT_MAX);

	// Counter saturates rather than wraps; an event on the clearing read counts as one
	assign fc_count_d = rd_fc_counter ? {{(CNT_W-1){1'b0}}, fc_event} :
	                    (fc_event & ~fc_sat) ? fc_count_q + 8'h01 : fc_count_q;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			fc_prev_q  <= 1'b0;
			fc_count_q <= RST_FC_COUNT;
		end else begin
			fc_prev_q  <= false_carrier_s;
			fc_count_q <= fc_count_d;
		end
	end

	sticky_flag #(
		.WIDTH (1)
	) u_fc_latch (
		.clock (clock),
		.reset (reset),
		.set   (fc_event),
		.clear (rd_fc_counter),
		.flag  (fc_latch)
	);

	//////////////////////////////////////////////////////////////////////////
	// Latch-low signal detect and descrambler lock

	logic sd_latch_q;
	logic sd_latch_d;
	logic dl_latch_q;
	logic dl_latch_d;

	// A drop always wins; only a quick status read re-arms to the live level
	assign sd_latch_d = ~signal_detect_s ? 1'b0 : rd_quick_status ? 1'b1 : sd_latch_q;
	assign dl_latch_d = ~descram_lock_s  ? 1'b0 : rd_quick_status ? 1'b1 : dl_latch_q;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sd_latch_q <= RST_FLAG;
			dl_latch_q <= RST_FLAG;
		end else begin
			sd_latch_q <= sd_latch_d;
			dl_latch_q <= dl_latch_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Page received, remote fault, jabber

	logic page_rx;
	logic remote_fault;
	logic jabber;

	sticky_flag #(
		.WIDTH (1)
	) u_page_rx (
		.clock (clock),
		.reset (reset),
		.set   (page_rx_s),
		.clear (rd_expansion),
		.flag  (page_rx)
	);

	sticky_flag #(
		.WIDTH (1)
	) u_remote_fault (
		.clock (clock),
		.reset (reset),
		.set   (remote_fault_s),
		.clear (rd_basic_status),
		.flag  (remote_fault)
	);

	// Jabber only has meaning in 10 Mb/s mode, so detection is gated there
	sticky_flag #(
		.WIDTH (1)
	) u_jabber (
		.clock (clock),
		.reset (reset),
		.set   (jabber_s & speed_10_s),
		.clear (rd_basic_status),
		.flag  (jabber)
	);

	//////////////////////////////////////////////////////////////////////////
	// Interrupt sources and enable

	logic [INT_W-1:0] int_enable_q;
	logic [INT_W-1:0] int_enable_d;
	logic [INT_W-1:0] int_source;

	assign int_enable_d = wr_int_enable ? writedata[INT_W-1:0] : int_enable_q;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			int_enable_q <= RST_INT_ENABLE;
		end else begin
			int_enable_q <= int_enable_d;
		end
	end

	// Disabled sources still latch, so enabling later reveals history
	sticky_flag #(
		.WIDTH (INT_W)
	) u_int_source (
		.clock (clock),
		.reset (reset),
		.set   (int_event_sync),
		.clear (rd_int_source),
		.flag  (int_source)
	);

	wire int_pending = |(int_source & int_enable_q);

	//////////////////////////////////////////////////////////////////////////
	// Register images

	logic [REG_W-1:0] quick_status_img;
	logic [REG_W-1:0] basic_status_img;
	logic [REG_W-1:0] expansion_img;

	always_comb begin
		quick_status_img                   = '0;
		quick_status_img[QS_FALSE_CARRIER] = fc_latch;
		quick_status_img[QS_SIGNAL_DETECT] = sd_latch_q;
		quick_status_img[QS_DESCRAM_LOCK]  = dl_latch_q;
		quick_status_img[QS_PAGE_RECEIVED] = page_rx;
		quick_status_img[QS_INT_PENDING]   = int_pending;
		quick_status_img[QS_REMOTE_FAULT]  = remote_fault;
		quick_status_img[QS_JABBER]        = jabber;
	end

	always_comb begin
		basic_status_img                   = '0;
		basic_status_img[BMS_REMOTE_FAULT] = remote_fault;
		basic_status_img[BMS_LINK_STATUS]  = link_up_s;
		basic_status_img[BMS_JABBER]       = jabber;
	end

	always_comb begin
		expansion_img                    = '0;
		expansion_img[ANX_PAGE_RECEIVED] = page_rx;
	end

	//////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped indexes read zero and ignore writes

	logic [DATA_W-1:0] read_mux;

	always_comb begin
		case (address)
			IDX_BASIC_MODE_STATUS: begin
				read_mux = {16'h0000, basic_status_img};
			end
			IDX_AUTONEG_EXPANSION: begin
				read_mux = {16'h0000, expansion_img};
			end
			IDX_PHY_QUICK_STATUS: begin
				read_mux = {16'h0000, quick_status_img};
			end
			IDX_INTERRUPT_ENABLE: begin
				read_mux = {24'h00_0000, int_enable_q};
			end
			IDX_INTERRUPT_SOURCE: begin
				read_mux = {24'h00_0000, int_source};
			end
			IDX_FALSE_CARRIER_CNT: begin
				read_mux = {24'h00_0000, fc_count_q};
			end
			default: begin
				read_mux = READ_ZERO;
			end
		endcase
	end

	logic [DATA_W-1:0] readdata_q;
	logic [DATA_W-1:0] readdata_d;

	assign readdata_d = rd_take ? read_mux : readdata_q;
	assign readdata   = readdata_q;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			readdata_q <= READ_ZERO;
		end else begin
			readdata_q <= readdata_d;
		end
	end

endmodule

// file: testbench/phy_quick_status_chk.sv
// Port-level checks of the quick status bank
module phy_quick_status_chk
	import phy_status_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              reset,
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [DATA_W-1:0] readdata,
	input  wire logic              waitrequest,
	input  wire logic              signal_detect_in,
	input  wire logic              descrambler_lock_in
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	wire acc = read && !waitrequest;
	wire qs  = acc && address == IDX_PHY_QUICK_STATUS;
	wire map = address inside {IDX_BASIC_MODE_STATUS, IDX_AUTONEG_EXPANSION, IDX_PHY_QUICK_STATUS,
		IDX_INTERRUPT_ENABLE, IDX_INTERRUPT_SOURCE, IDX_FALSE_CARRIER_CNT};
	//////////////////////////////////////////////////////////////////////////////
	chk_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("more than one wait state");
	chk_idle_ready: assert property (!(read || write) |-> !waitrequest)
		else $error("waitrequest without request");
	chk_new_waits: assert property ((read || write) && !waitrequest ##1 (read || write) |-> waitrequest)
		else $error("back to back request not stalled");
	chk_upper_zero: assert property (acc |-> readdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	chk_quick_spare: assert property (qs |-> readdata[15:12] == 4'h0 && readdata[4:0] == 5'h00)
		else $error("bits outside the middle field set");
	// Depth 4 covers two sync flops, the latch and the capture edge
	chk_detect_low: assert property (qs && !$past(signal_detect_in, 4) |-> !readdata[QS_SIGNAL_DETECT])
		else $error("signal detect drop not latched");
	chk_lock_low: assert property (qs && !$past(descrambler_lock_in, 4) |-> !readdata[QS_DESCRAM_LOCK])
		else $error("descrambler lock drop not latched");
	chk_unmapped_zero: assert property (acc && !map |-> readdata == READ_ZERO)
		else $error("unmapped read not zero");
endmodule

bind phy_quick_status phy_quick_status_chk chk_u (.clock(clock), .reset(reset), .address(address), .read(read),
	.write(write), .readdata(readdata), .waitrequest(waitrequest), .signal_detect_in(signal_detect_in),
	.descrambler_lock_in(descrambler_lock_in));

// file: testbench/phy_quick_status_test.sv
// Self-checking bench for the quick status bank
module phy_quick_status_test;
	timeunit 1ns;
	timeprecision 1ns;
	import phy_status_pkg::*;
	logic              clock, reset, read, write, waitrequest;
	logic [ADDR_W-1:0] address;
	logic [DATA_W-1:0] writedata, readdata, d;
	logic [3:0]        byteenable;
	logic              false_carrier_in, signal_detect_in, descrambler_lock_in, page_received_in;
	logic              remote_fault_in, jabber_in, link_up_in, speed_10_in;
	logic [INT_W-1:0]  int_event_in;
	int                n_fail = 0, checked = 0, cycles = 0;

	phy_quick_status dut_u (.clock(clock), .reset(reset), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.false_carrier_in(false_carrier_in), .signal_detect_in(signal_detect_in),
		.descrambler_lock_in(descrambler_lock_in), .page_received_in(page_received_in),
		.remote_fault_in(remote_fault_in), .jabber_in(jabber_in), .link_up_in(link_up_in),
		.speed_10_in(speed_10_in), .int_event_in(int_event_in));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	//////////////////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Generous ceiling: the whole run is about 150 cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_fail++;
			finish_test();
		end
	end
	task automatic check(input logic [DATA_W-1:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	// Request held until waitrequest is seen low at a rising edge; only the bench timeout ends the wait
	task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] w, input logic [3:0] be);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= {24'h00_0000, w};
		byteenable <= be;
		do @(posedge clock); while (waitrequest !== 1'b0);
		d = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a);
		access(1'b0, a, 8'h00, 4'h0);
	endtask
	//////////////////////////////////////////////////////////////////////////////
	task automatic t_reset_map;
		rd(IDX_PHY_QUICK_STATUS);
		check(d, READ_ZERO);
		rd(5'h1f);
		check(d, READ_ZERO);
		access(1'b1, IDX_PHY_QUICK_STATUS, 8'hff, 4'hf);
		rd(IDX_PHY_QUICK_STATUS);
		check(d[QS_SIGNAL_DETECT:QS_DESCRAM_LOCK], 2'b11);
		$display("reset and map done");
	endtask
	task automatic t_latch_low;
		signal_detect_in <= 1'b0;
		tick(1);
		signal_detect_in <= 1'b1;
		tick(2);
		rd(IDX_PHY_QUICK_STATUS);
		check(d[QS_SIGNAL_DETECT:QS_DESCRAM_LOCK], 2'b01);
		descrambler_lock_in <= 1'b0;
		tick(3);
		descrambler_lock_in <= 1'b1;
		rd(IDX_PHY_QUICK_STATUS);
		check(d[QS_SIGNAL_DETECT:QS_DESCRAM_LOCK], 2'b10);
		// Re-arm was lost to the drop still in the synchroniser
		rd(IDX_PHY_QUICK_STATUS);
		check(d[QS_SIGNAL_DETECT:QS_DESCRAM_LOCK], 2'b10);
		rd(IDX_PHY_QUICK_STATUS);
		check(d[QS_SIGNAL_DETECT:QS_DESCRAM_LOCK], 2'b11);
		$display("latch low done");
	endtask
	task automatic t_false_carrier;
		false_carrier_in <= 1'b1;
		tick(3);
		false_carrier_in <= 1'b0;
		tick(5);
		rd(IDX_PHY_QUICK_STATUS);
		check(d[QS_FALSE_CARRIER], 1'b1);
		rd(IDX_PHY_QUICK_STATUS);
		check(d[QS_FALSE_CARRIER], 1'b1);
		rd(IDX_FALSE_CARRIER_CNT);
		check(d, 32'h0000_0001);
		rd(IDX_PHY_QUICK_STATUS);
		check(d[QS_FALSE_CARRIER], 1'b0);
		$display("false carrier done");
	endtask
	task automatic t_page;
		page_received_in <= 1'b1;
		tick(3);
		page_received_in <= 1'b0;
		tick(5);
		rd(IDX_PHY_QUICK_STATUS);
		check(d[QS_PAGE_RECEIVED], 1'b1);
		rd(IDX_PHY_QUICK_STATUS);
		check(d[QS_PAGE_RECEIVED], 1'b1);
		rd(IDX_AUTONEG_EXPANSION);
		check(d[ANX_PAGE_RECEIVED], 1'b1);
		rd(IDX_PHY_QUICK_STATUS);
		check(d[QS_PAGE_RECEIVED], 1'b0);
		$display("page received done");
	endtask
	task automatic t_interrupt;
		access(1'b1, IDX_INTERRUPT_ENABLE, 8'h01, 4'h0);
		rd(IDX_INTERRUPT_ENABLE);
		check(d, 32'h0000_0000);
		access(1'b1, IDX_INTERRUPT_ENABLE, 8'h01, 4'h1);
		int_event_in <= 8'h02;
		tick(3);
		int_event_in <= 8'h00;
		tick(5);
		rd(IDX_PHY_QUICK_STATUS);
		check(d[QS_INT_PENDING], 1'b0);
		int_event_in <= 8'h01;
		tick(3);
		int_event_in <= 8'h00;
		tick(5);
		rd(IDX_PHY_QUICK_STATUS);
		check(d[QS_INT_PENDING], 1'b1);
		rd(IDX_INTERRUPT_SOURCE);
		check(d, 32'h0000_0003);
		rd(IDX_PHY_QUICK_STATUS);
		check(d[QS_INT_PENDING], 1'b0);
		$display("interrupt done");
	endtask
	// Read held high across two transfers, only the address moves
	task automatic t_back_to_back;
		address <= IDX_INTERRUPT_ENABLE;
		read <= 1'b1;
		do @(posedge clock); while (waitrequest !== 1'b0);
		check(readdata, 32'h0000_0001);
		address <= IDX_FALSE_CARRIER_CNT;
		do @(posedge clock); while (waitrequest !== 1'b0);
		check(readdata, READ_ZERO);
		read <= 1'b0;
		@(posedge clock);
		$display("back to back done");
	endtask
	task automatic t_fault_jabber;
		remote_fault_in <= 1'b1;
		jabber_in <= 1'b1;
		tick(3);
		remote_fault_in <= 1'b0;
		jabber_in <= 1'b0;
		tick(5);
		rd(IDX_PHY_QUICK_STATUS);
		check(d[QS_REMOTE_FAULT:QS_JABBER], 2'b10);
		speed_10_in <= 1'b1;
		jabber_in <= 1'b1;
		tick(3);
		jabber_in <= 1'b0;
		tick(5);
		rd(IDX_PHY_QUICK_STATUS);
		check(d[QS_REMOTE_FAULT:QS_JABBER], 2'b11);
		rd(IDX_PHY_QUICK_STATUS);
		check(d[QS_JABBER], 1'b1);
		rd(IDX_BASIC_MODE_STATUS);
		check(d, 32'h0000_0016);
		rd(IDX_PHY_QUICK_STATUS);
		check(d[QS_REMOTE_FAULT:QS_JABBER], 2'b00);
		$display("fault and jabber done");
	endtask
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		{reset, read, write, address, writedata, byteenable} = '0;
		{false_carrier_in, page_received_in, remote_fault_in, jabber_in, speed_10_in, int_event_in} = '0;
		reset = 1'b1;
		signal_detect_in = 1'b1;
		descrambler_lock_in = 1'b1;
		link_up_in = 1'b1;
		tick(4);
		reset <= 1'b0;
		// Let the synchronisers fill so the first read re-arms the latch-low bits
		tick(3);
		t_reset_map();
		t_latch_low();
		t_false_carrier();
		t_page();
		t_interrupt();
		t_back_to_back();
		t_fault_jabber();
		finish_test();
	end
endmodule
